// [core/sarc_defines.svh]
// register offsets, field positions, reset values and timing counts of the converter control
`ifndef SARC_DEFINES_SVH
`define SARC_DEFINES_SVH

// ------------------------------------------------------------------
// register byte offsets
// ------------------------------------------------------------------
`define SARC_OFS_CTRL0     4'h0
`define SARC_OFS_CTRL1     4'h1
`define SARC_OFS_CTRL2     4'h2
`define SARC_OFS_RES_HIGH  4'h3
`define SARC_OFS_RES_LOW   4'h4
`define SARC_OFS_FLAGS     4'h5
`define SARC_OFS_PORT      4'h6
`define SARC_OFS_SAMPLE    4'h7

// ------------------------------------------------------------------
// field positions
// ------------------------------------------------------------------
`define SARC_C0_ON         0
`define SARC_C0_GO         1
`define SARC_C0_CHAN_LSB   2
`define SARC_C1_VNEG       5
`define SARC_C1_VPOS       4
`define SARC_C2_CLK_LSB    0
`define SARC_C2_ACQ_LSB    3
`define SARC_FL_DONE       0
`define SARC_FL_IRQ_EN     1
`define SARC_FL_GIE        2
`define SARC_FL_BUSY       3

// ------------------------------------------------------------------
// reset values
// ------------------------------------------------------------------
`define SARC_RST_CTRL0     8'h00
`define SARC_RST_CTRL1     8'h00
`define SARC_RST_CTRL2     8'h00
`define SARC_RST_ANSEL     8'hFF

// ------------------------------------------------------------------
// timing counts
// ------------------------------------------------------------------
`define SARC_GAP_PERIODS   2
`define SARC_DELAY_CYCLES  1
`define SARC_RC_DIV        8

`endif

// [core/sarc_pkg.sv]
// types shared by the converter control modules
package sarc_pkg;

  typedef enum logic [2:0]
  {
    SARC_IDLE    = 3'b000,
    SARC_DELAY   = 3'b001,
    SARC_ACQUIRE = 3'b011,
    SARC_CONVERT = 3'b010,
    SARC_GAP     = 3'b110
  } sarc_state_type;

  typedef logic [2:0] sarc_sel_type;

endpackage : sarc_pkg

// [core/sarc_tick_if.sv]
// tick and clock selection between the controller and the period generator
`timescale 1ns/10ps
interface sarc_tick_if;
  import sarc_pkg::*;
  sarc_sel_type clk_sel;
  logic         use_rc;
  logic         tick;
  modport ctrl (output clk_sel, output use_rc, input tick);
  modport gen  (input clk_sel, input use_rc, output tick);
endinterface : sarc_tick_if

// [core/sarc_tick_gen.sv]
// bit-conversion period tick generator
`timescale 1ns/10ps
`include "sarc_defines.svh"
module sarc_tick_gen
#(
  parameter int RC_DIV = `SARC_RC_DIV
)
(
  input  wire logic clk,
  input  wire logic srst,
  input  wire logic rc_osc_tick,
  sarc_tick_if.gen  tif
);
  import sarc_pkg::*;

  initial
  begin
    if (RC_DIV < 1 || RC_DIV > 256)
    begin
      $error("RC_DIV must be at least 1");
    end
  end

  logic [7:0] count;
  logic [7:0] limit;
  logic       step;

  // ------------------------------------------------------------------
  // period select
  // ------------------------------------------------------------------
  // rc source ticks on the internal oscillator, so it keeps going in sleep
  always_comb
  begin
    step  = tif.use_rc ? rc_osc_tick : 1'b1;
    limit = tif.use_rc ? 8'(RC_DIV - 1) : 8'((8'h02 << tif.clk_sel) - 8'h01);
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      count <= 8'h00;
    end
    else if (step)
    begin
      count <= (count >= limit) ? 8'h00 : count + 8'h01;
    end
  end

  assign tif.tick = step && (count >= limit);

endmodule : sarc_tick_gen

// [core/sarc_top.sv]
// successive approximation converter control with avalon register slave
//
// Contract
// - software picks supply rails or the reference pins per rail.
// - internal rc clock source keeps conversions running during sleep.
// - sample-hold feeds the core; one result bit per bit period.
// - reset restores registers, turns module off, aborts conversion.
// - on finish load result, clear go bit, set done flag.
// - result bytes are untouched by reset, unknown at power-up.
// - programmable acquisition delay between go and conversion start.
// - bit period derives from the selected conversion clock.
// - at least two bit periods after finishing before next acquisition.
// - each shared pin is individually analog or digital.
// - acquisition select zero delays conversion one instruction cycle.
// - port reads return zero on pins set as analog inputs.
`timescale 1ns/10ps
`include "sarc_defines.svh"
module sarc_top
#(
  parameter int RC_DIV        = `SARC_RC_DIV,
  parameter int INSTR_CYCLES  = 4,
  parameter int RESULT_BITS   = 12
)
(
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        rc_osc_tick,
  input  wire logic [7:0]  port_pins,
  input  wire logic        cmp_high,
  output logic             sample_hold,
  output logic [11:0]      dac_code,
  output logic [2:0]       channel_sel,
  output logic             vref_pos_pin,
  output logic             vref_neg_pin,
  output logic [7:0]       analog_pins,
  output logic             irq
);
  import sarc_pkg::*;

  initial
  begin
    if (RESULT_BITS != 12 || INSTR_CYCLES < 1 || INSTR_CYCLES > 256)
    begin
      $error("unsupported result width or instruction cycle");
    end
  end

  sarc_tick_if tif ();

  sarc_tick_gen #(.RC_DIV(RC_DIV)) u_tick
  (
    .clk         (clk),
    .srst        (srst),
    .rc_osc_tick (rc_osc_tick),
    .tif         (tif)
  );

  // ------------------------------------------------------------------
  // registers and state
  // ------------------------------------------------------------------
  logic [7:0]      converter_control_0;
  logic [7:0]      converter_control_1;
  logic [7:0]      converter_control_2;
  logic [7:0]      ansel;
  logic [7:0]      result_high_byte;
  logic [7:0]      result_low_byte;
  logic            conversion_done_irq_flag;
  logic            conversion_irq_enable;
  logic            global_irq_enable;
  sarc_state_type  state;
  logic [3:0]      bit_idx;
  logic [11:0]     sar;
  logic [4:0]      period_cnt;
  logic [7:0]      delay_cnt;
  logic [7:0]      pin_s1;
  logic [7:0]      pin_s2;
  logic [7:0]      pin_s3;
  logic [7:0]      port_view;
  logic            cmp_s1;
  logic            cmp_s2;
  logic            cmp_s3;
  logic            cmp_view;
  logic            rd_done;
  logic            wr_ctrl0;
  logic            finish;
  logic            go_start;
  logic [2:0]      acq_sel;

  assign acq_sel   = converter_control_2[`SARC_C2_ACQ_LSB +: 3];
  assign wr_ctrl0  = avs_write && avs_address == `SARC_OFS_CTRL0;
  // go only counts with the module on
  assign go_start  = wr_ctrl0 && avs_writedata[`SARC_C0_GO]
                     && avs_writedata[`SARC_C0_ON] && state == SARC_IDLE;
  assign finish    = state == SARC_CONVERT && tif.tick && bit_idx == 4'h0;

  assign tif.clk_sel = converter_control_2[`SARC_C2_CLK_LSB +: 3];
  assign tif.use_rc  = converter_control_2[`SARC_C2_CLK_LSB +: 3] == 3'h7;

  // acquisition periods from the select field
  function automatic logic [4:0] acq_periods(input logic [2:0] sel);
    acq_periods = (sel == 3'h0) ? 5'h00 : 5'(sel) << 1;
  endfunction : acq_periods

  // ------------------------------------------------------------------
  // pin inputs, three stage synchronisers
  // ------------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    pin_s1 <= port_pins;
    pin_s2 <= pin_s1;
    pin_s3 <= pin_s2;
    cmp_s1 <= cmp_high;
    cmp_s2 <= cmp_s1;
    cmp_s3 <= cmp_s2;
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      port_view <= 8'h00;
      cmp_view  <= 1'b0;
    end
    else
    begin
      port_view <= (pin_s2 & pin_s3) | (port_view & (pin_s2 | pin_s3));
      cmp_view  <= (cmp_s2 & cmp_s3) | (cmp_view & (cmp_s2 | cmp_s3));
    end
  end

  // ------------------------------------------------------------------
  // control registers
  // ------------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      converter_control_0 <= `SARC_RST_CTRL0;
      converter_control_1 <= `SARC_RST_CTRL1;
      converter_control_2 <= `SARC_RST_CTRL2;
      ansel               <= `SARC_RST_ANSEL;
      conversion_irq_enable <= 1'b0;
      global_irq_enable     <= 1'b0;
    end
    else
    begin
      if (wr_ctrl0)
      begin
        // a write while busy keeps go unless it turns the module off
        converter_control_0 <= {avs_writedata[7:2],
                                go_start || (converter_control_0[`SARC_C0_GO] && !finish
                                             && avs_writedata[`SARC_C0_ON]),
                                avs_writedata[0]};
      end
      else if (finish)
      begin
        converter_control_0[`SARC_C0_GO] <= 1'b0;
      end
      if (avs_write && avs_address == `SARC_OFS_CTRL1)
      begin
        converter_control_1 <= avs_writedata[7:0];
      end
      if (avs_write && avs_address == `SARC_OFS_CTRL2)
      begin
        converter_control_2 <= avs_writedata[7:0];
      end
      if (avs_write && avs_address == `SARC_OFS_PORT)
      begin
        ansel <= avs_writedata[7:0];
      end
      if (avs_write && avs_address == `SARC_OFS_FLAGS)
      begin
        conversion_irq_enable <= avs_writedata[`SARC_FL_IRQ_EN];
        global_irq_enable     <= avs_writedata[`SARC_FL_GIE];
      end
    end
  end

  // set wins over a clear in the same cycle
  assign rd_done = avs_write && avs_address == `SARC_OFS_FLAGS
                   && !avs_writedata[`SARC_FL_DONE];

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      conversion_done_irq_flag <= 1'b0;
    end
    else if (finish)
    begin
      conversion_done_irq_flag <= 1'b1;
    end
    else if (rd_done)
    begin
      conversion_done_irq_flag <= 1'b0;
    end
  end

  // ------------------------------------------------------------------
  // conversion sequencer
  // ------------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      state      <= SARC_IDLE;
      bit_idx    <= 4'h0;
      sar        <= 12'h000;
      period_cnt <= 5'h00;
      delay_cnt  <= 8'h00;
    end
    else if (!converter_control_0[`SARC_C0_ON] && state != SARC_IDLE)
    begin
      state <= SARC_IDLE;
    end
    else
    begin
      unique case (state)
        SARC_IDLE:
        begin
          if (go_start && acq_sel == 3'h0)
          begin
            state     <= SARC_DELAY;
            delay_cnt <= 8'(INSTR_CYCLES - 1);
          end
          else if (go_start)
          begin
            state      <= SARC_ACQUIRE;
            period_cnt <= acq_periods(acq_sel);
          end
        end
        SARC_DELAY:
        begin
          // start on a period boundary so the first trial bit gets a full period
          if (delay_cnt != 8'h00)
          begin
            delay_cnt <= delay_cnt - 8'h01;
          end
          else if (tif.tick)
          begin
            state   <= SARC_CONVERT;
            bit_idx <= 4'(RESULT_BITS - 1);
            sar     <= 12'h800;
          end
        end
        SARC_ACQUIRE:
        begin
          // first tick after go may be partial, one extra tick keeps full acquisition
          if (tif.tick)
          begin
            if (period_cnt == 5'h00)
            begin
              state   <= SARC_CONVERT;
              bit_idx <= 4'(RESULT_BITS - 1);
              sar     <= 12'h800;
            end
            else
            begin
              period_cnt <= period_cnt - 5'h01;
            end
          end
        end
        SARC_CONVERT:
        begin
          if (tif.tick)
          begin
            // keep or drop the trial bit, then try the next lower one
            sar[bit_idx] <= cmp_view;
            if (bit_idx == 4'h0)
            begin
              state      <= SARC_GAP;
              period_cnt <= 5'(`SARC_GAP_PERIODS);
            end
            else
            begin
              sar[bit_idx - 4'h1] <= 1'b1;
              bit_idx             <= bit_idx - 4'h1;
            end
          end
        end
        SARC_GAP:
        begin
          if (tif.tick)
          begin
            if (period_cnt <= 5'h01)
            begin
              state <= SARC_IDLE;
            end
            else
            begin
              period_cnt <= period_cnt - 5'h01;
            end
          end
        end
        default:
        begin
          state <= SARC_IDLE;
        end
      endcase
    end
  end

  // ------------------------------------------------------------------
  // result bytes, no reset so contents survive
  // ------------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (finish)
    begin
      result_high_byte <= {4'h0, sar[11:8]};
      result_low_byte  <= {sar[7:1], cmp_view};
    end
  end

  // ------------------------------------------------------------------
  // analog side outputs
  // ------------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      sample_hold  <= 1'b0;
      dac_code     <= 12'h000;
      channel_sel  <= 3'h0;
      vref_pos_pin <= 1'b0;
      vref_neg_pin <= 1'b0;
      analog_pins  <= `SARC_RST_ANSEL;
      irq          <= 1'b0;
    end
    else
    begin
      sample_hold  <= state == SARC_CONVERT || state == SARC_DELAY;
      dac_code     <= sar;
      channel_sel  <= converter_control_0[`SARC_C0_CHAN_LSB +: 3];
      vref_pos_pin <= converter_control_1[`SARC_C1_VPOS];
      vref_neg_pin <= converter_control_1[`SARC_C1_VNEG];
      analog_pins  <= ansel;
      irq          <= conversion_done_irq_flag && conversion_irq_enable && global_irq_enable;
    end
  end

  // ------------------------------------------------------------------
  // avalon slave, zero wait states
  // ------------------------------------------------------------------
  assign avs_waitrequest = 1'b0;

  always_comb
  begin
    avs_readdata = 32'h0000_0000;
    unique case (avs_address)
      `SARC_OFS_CTRL0:    avs_readdata[7:0] = converter_control_0;
      `SARC_OFS_CTRL1:    avs_readdata[7:0] = converter_control_1;
      `SARC_OFS_CTRL2:    avs_readdata[7:0] = converter_control_2;
      `SARC_OFS_RES_HIGH: avs_readdata[7:0] = {4'h0, result_high_byte[3:0]};
      `SARC_OFS_RES_LOW:  avs_readdata[7:0] = result_low_byte;
      `SARC_OFS_FLAGS:    avs_readdata[3:0] = {state != SARC_IDLE, global_irq_enable,
                                               conversion_irq_enable, conversion_done_irq_flag};
      `SARC_OFS_PORT:     avs_readdata[7:0] = ansel;
      `SARC_OFS_SAMPLE:   avs_readdata[7:0] = port_view & ~ansel;
      default:            avs_readdata = 32'h0000_0000;
    endcase
  end

endmodule : sarc_top

// [testbench/sarc_top_sva.sv]
// concurrent checks on the converter control ports
`timescale 1ns/10ps
module sarc_top_sva
(
  input wire logic        clk,
  input wire logic        srst,
  input wire logic [3:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic        rc_osc_tick,
  input wire logic [7:0]  port_pins,
  input wire logic        cmp_high,
  input wire logic        sample_hold,
  input wire logic [11:0] dac_code,
  input wire logic [2:0]  channel_sel,
  input wire logic        vref_pos_pin,
  input wire logic        vref_neg_pin,
  input wire logic [7:0]  analog_pins,
  input wire logic        irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);

  // ----------------------------------------
  // port relations
  // ----------------------------------------
  a_reset_off:
    assert property ($fell(srst) |-> analog_pins == 8'hFF && !sample_hold && !irq)
    else $error("outputs not at reset values after reset");
  a_vref_follow:
    assert property (avs_write && avs_address == 4'h1 |-> ##2 vref_pos_pin ==
      $past(avs_writedata[4], 2) && vref_neg_pin == $past(avs_writedata[5], 2))
    else $error("reference selection pins do not follow control 1");
  a_chan_follow:
    assert property (avs_write && avs_address == 4'h0 |-> ##2
      channel_sel == $past(avs_writedata[4:2], 2))
    else $error("channel select does not follow control 0");
  a_analog_follow:
    assert property (avs_write && avs_address == 4'h6 |-> ##2
      analog_pins == $past(avs_writedata[7:0], 2))
    else $error("analog pin selection does not follow its register");
  // one cycle of guard since the pin copy may lag the register
  a_port_mask:
    assert property (avs_read && avs_address == 4'h7 && !$past(avs_write) |->
      (avs_readdata[7:0] & analog_pins) == 8'h00)
    else $error("analog pin reads nonzero on port read");
  a_result_just:
    assert property (avs_read && avs_address == 4'h3 |-> avs_readdata[31:4] == 28'h0)
    else $error("result high byte not right justified");
  a_unmapped_zero:
    assert property (avs_read && avs_address[3] |-> avs_readdata == 32'h0)
    else $error("unmapped read not zero");
  a_off_no_start:
    assert property (avs_write && avs_address == 4'h0 && avs_writedata[1:0] == 2'b10
      |=> ##1 !sample_hold [*6])
    else $error("go while off started a conversion");
  a_gap_after:
    assert property ($fell(sample_hold) |-> !sample_hold [*3])
    else $error("new sampling too soon after conversion end");

  c_conv_end: cover property ($fell(sample_hold));
  c_port_read: cover property (avs_read && avs_address == 4'h7);
  c_irq_rise: cover property ($rose(irq));
endmodule : sarc_top_sva

bind sarc_top sarc_top_sva sarc_top_sva_i (.clk, .srst, .avs_address, .avs_read, .avs_write,
  .avs_writedata, .avs_readdata, .avs_waitrequest, .rc_osc_tick, .port_pins, .cmp_high,
  .sample_hold, .dac_code, .channel_sel, .vref_pos_pin, .vref_neg_pin, .analog_pins, .irq);

// [testbench/sarc_top_tb.sv]
// self-checking bench for the converter control
`timescale 1ns/10ps
`include "sarc_defines.svh"
module sarc_top_tb;
  localparam int RC_DIV = 4;
  localparam int INSTR  = 1;
  logic        clk, srst, avs_read, avs_write;
  logic        rc_osc_tick = 1'b0, cmp_high = 1'b0;
  logic        avs_waitrequest, sample_hold, vref_pos_pin, vref_neg_pin, irq;
  logic [3:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic [7:0]  port_pins, analog_pins, d;
  logic [11:0] dac_code, vin;
  logic [2:0]  channel_sel;
  integer      seed = 32'h50f8;
  int          miscompares = 0, comparisons = 0, cyc = 0;

  sarc_top #(.RC_DIV(RC_DIV), .INSTR_CYCLES(INSTR)) sarc_top_i (.clk, .srst, .avs_address,
    .avs_read, .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest, .rc_osc_tick,
    .port_pins, .cmp_high, .sample_hold, .dac_code, .channel_sel, .vref_pos_pin,
    .vref_neg_pin, .analog_pins, .irq);

  // ----------------------------------------
  // clock, analog side, watchdog
  // ----------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // input above trial when vin >= trial: the input sits half a step above vin
  always @(posedge clk)
  begin
    cmp_high <= vin >= dac_code;
    rc_osc_tick <= ~rc_osc_tick;
    cyc <= cyc + 1;
    if (cyc == 100000)
    begin
      miscompares++;
      end_of_test();
    end
  end

  // ----------------------------------------
  // tasks and expectations
  // ----------------------------------------
  task automatic end_of_test();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : end_of_test

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e)
    begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] wd);
    @(posedge clk);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= {24'h0, wd};
    @(posedge clk);
    while (avs_waitrequest !== 1'b0) @(posedge clk);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus

  function automatic int per_of(input int sel);
    return (sel == 7) ? 2 * RC_DIV : 2 << sel;
  endfunction : per_of

  function automatic int conv_time(input int sel, input int acq);
    return ((acq == 0) ? INSTR : 2 * acq * per_of(sel)) + 12 * per_of(sel);
  endfunction : conv_time

  // trial periods under 8 cycles race the 3-stage comparator sync, so sel starts at 2
  task automatic convert(input int sel, input int acq);
    int t0;
    int t;
    vin = 12'($random(seed));
    bus(1'b1, `SARC_OFS_CTRL2, 8'((acq << 3) | sel));
    bus(1'b1, `SARC_OFS_FLAGS, 8'h06);
    bus(1'b1, `SARC_OFS_CTRL0, 8'h03 | 8'(sel << 2));
    t0 = cyc;
    bus(1'b0, `SARC_OFS_CTRL0, 8'h00);
    chk("go held", 1, rd[1]);
    while (rd[1] === 1'b1) bus(1'b0, `SARC_OFS_CTRL0, 8'h00);
    t = cyc - t0;
    chk("conversion time", 1, t >= conv_time(sel, acq));
    chk("conversion bound", 1, t <= conv_time(sel, acq) + 2 * per_of(sel) + 12);
    bus(1'b0, `SARC_OFS_FLAGS, 8'h00);
    chk("flags", 3'h7, rd[2:0]);
    if (sel != 7) chk("busy in gap", 1, rd[3]);
    chk("irq", 1, irq);
    chk("trial code", vin, dac_code);
    bus(1'b0, `SARC_OFS_RES_HIGH, 8'h00);
    chk("result high", {4'h0, vin[11:8]}, rd);
    bus(1'b0, `SARC_OFS_RES_LOW, 8'h00);
    chk("result low", vin[7:0], rd);
    bus(1'b1, `SARC_OFS_FLAGS, 8'h06);
    repeat (2) @(posedge clk);
    chk("irq cleared", 0, irq);
    rd = 32'h8;
    while (rd[3] === 1'b1) bus(1'b0, `SARC_OFS_FLAGS, 8'h00);
  endtask : convert

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    srst = 1'b1;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 4'h0;
    avs_writedata = 32'h0;
    port_pins = 8'h00;
    vin = 12'h000;
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    for (int a = 0; a < 7; a++)
    begin
      bus(1'b0, 4'(a), 8'h00);
      if (a < 3 || a == 5) chk("reset value", 0, rd);
      if (a == 6) chk("analog reset", 8'hFF, rd);
    end
    repeat (6)
    begin
      d = 8'($random(seed));
      bus(1'b1, `SARC_OFS_CTRL1, d);
      bus(1'b0, `SARC_OFS_CTRL1, 8'h00);
      chk("reference select", d & 8'h30, rd & 32'h30);
      chk("reference pins", d[5:4], {vref_neg_pin, vref_pos_pin});
      bus(1'b1, `SARC_OFS_PORT, d);
      port_pins <= 8'($random(seed));
      repeat (5) @(posedge clk);
      bus(1'b0, `SARC_OFS_SAMPLE, 8'h00);
      chk("port read", port_pins & ~d, rd);
    end
    for (int a = 8; a < 16; a++)
    begin
      bus(1'b1, 4'(a), 8'hFF);
      bus(1'b0, 4'(a), 8'h00);
      chk("unmapped", 0, rd);
    end
    bus(1'b1, `SARC_OFS_CTRL0, 8'h02);
    bus(1'b0, `SARC_OFS_CTRL0, 8'h00);
    chk("go while off", 0, rd[1:0]);
    convert(7, 0);
    convert(2, 7);
    repeat (8) convert(2 + {$random(seed)} % 6, {$random(seed)} % 8);
    bus(1'b1, `SARC_OFS_CTRL2, 8'h3B);
    bus(1'b1, `SARC_OFS_CTRL0, 8'h03);
    repeat (40) @(posedge clk);
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    bus(1'b0, `SARC_OFS_CTRL0, 8'h00);
    chk("aborted go", 0, rd);
    bus(1'b0, `SARC_OFS_FLAGS, 8'h00);
    chk("aborted flags", 0, rd);
    bus(1'b0, `SARC_OFS_RES_LOW, 8'h00);
    chk("result kept", vin[7:0], rd);
    convert(3, 1);
    end_of_test();
  end
endmodule : sarc_top_tb
